// File: verilog/serial_audio_input_volume_path.sv
// Serial audio receiver, DC filter, boost, ramped volume and clipper.
// Assumes bit clock, frame clock and data come from one audio source.
`timescale 1ns/100ps

// ----------------------------------------
// Receiver on the bit clock
// ----------------------------------------
module frame_rx (
  input  wire logic        serial_bit_clock,    // Link clock
  input  wire logic        resetn,              // Core reset, resynchronised
  input  wire logic        channel_frame_clock, // Frame clock
  input  wire logic        serial_data,         // Serial data
  input  wire logic [1:0]  fmt,                 // Format, core domain
  input  wire logic [4:0]  wl,                  // Word length, core domain
  output logic      [23:0] word,                // Last channel word
  output logic             chan_r,              // Word is right channel
  output logic             ok,                  // Bit count was legal
  output logic             tog                  // Toggles per word
);
  typedef struct packed {
    logic [1:0]  rst_s;
    logic [1:0]  fmt_m, fmt_s;
    logic [4:0]  wl_m, wl_s;
    logic        lr_d;
    logic [5:0]  cnt;
    logic [23:0] sr, word;
    logic        chan_r, ok, tog;
  } rx_st_t;
  rx_st_t q, d;
  logic [5:0]  k;
  logic [23:0] rj;
  logic        edge_s;

  assign edge_s = channel_frame_clock != q.lr_d;

  // Shift, count and hand over one word per half frame
  always_comb begin
    d = q;
    k = (q.fmt_s == audio_path_pkg::FMT_LJ) ? q.cnt + 6'h01 : q.cnt;
    rj = (q.sr & ~(24'hFFFFFF << q.wl_s)) << (5'h18 - q.wl_s);
    d.rst_s = {q.rst_s[0], resetn};
    d.fmt_m = fmt;
    d.fmt_s = q.fmt_m;
    d.wl_m  = wl;
    d.wl_s  = q.wl_m;
    d.lr_d  = channel_frame_clock;
    if (edge_s) begin
      d.cnt  = 6'h00;
      // RJ word ends just before toggle
      d.word = (q.fmt_s == audio_path_pkg::FMT_RJ) ? rj : q.sr;
      d.chan_r = (q.fmt_s == audio_path_pkg::FMT_I2S) ? q.lr_d : !q.lr_d;
      // 16, 24 or 32 bits per half frame
      d.ok  = (q.cnt == 6'h0F) || (q.cnt == 6'h17) || (q.cnt == 6'h1F);
      d.tog = !q.tog;
      // LJ MSB arrives with the toggle
      if (q.fmt_s == audio_path_pkg::FMT_LJ)
        d.sr = {serial_data, 23'h000000};
      else if (q.fmt_s == audio_path_pkg::FMT_RJ)
        d.sr = {23'h000000, serial_data};
      else
        d.sr = 24'h000000;
    end else begin
      if (q.cnt != 6'h3F)
        d.cnt = q.cnt + 6'h01;
      if (q.fmt_s == audio_path_pkg::FMT_RJ)
        d.sr = {q.sr[22:0], serial_data};
      // I2S index starts one clock late
      // bits past word length stay zero
      else if (k < 6'(q.wl_s))
        d.sr[5'(6'h17 - k)] = serial_data;
    end
    if (!q.rst_s[1]) begin
      d = '0;
      d.rst_s = {q.rst_s[0], resetn};
    end
  end

  always_ff @(posedge serial_bit_clock) begin
    q <= d;
  end

  assign word   = q.word;
  assign chan_r = q.chan_r;
  assign ok     = q.ok;
  assign tog    = q.tog;

  default clocking rx_cb @(posedge serial_bit_clock); endclocking
  default disable iff (!q.rst_s[1]);

  rx_tog_a: assert property (edge_s |=> tog != $past(tog))
    else $error("word not handed over at frame edge");
  rx_lj_msb_a: assert property (edge_s && q.fmt_s == audio_path_pkg::FMT_LJ |=> q.sr[23] == $past(serial_data))
    else $error("left justified MSB not taken at toggle");
endmodule

// ----------------------------------------
// Core path on core_clk
// ----------------------------------------
module serial_audio_input_volume_path #(
  parameter int DC_FRAMES = 4800 // Frames of output DC before fault
) (
  input  wire logic        core_clk,              // Core clock
  input  wire logic        resetn,                // Sync reset, low
  input  wire logic        serial_bit_clock,      // Link bit clock
  input  wire logic        channel_frame_clock,   // Frame clock
  input  wire logic        serial_data,           // Serial data
  input  wire logic        sw_mode,               // High: register control
  input  wire logic        reg_wr,                // Register write strobe
  input  wire logic [7:0]  reg_addr,              // Register offset
  input  wire logic [7:0]  reg_wdata,             // Write data
  output logic      [7:0]  reg_rdata,             // Read data, next cycle
  input  wire logic        speaker_shutdown_n,    // Shutdown pin, low
  input  wire logic        speaker_fault_n_i,     // Fault line level
  output logic             speaker_fault_n_o,     // Fault drive value
  output logic             speaker_fault_n_oe,    // Fault pulled low
  input  wire logic        soft_clip_pin,         // Clipper enable pin
  input  wire logic        line_driver_mute,      // Line driver mute pin
  input  wire logic        line_driver_uv_enable, // Line driver enable pin
  output logic             line_mute_out,         // To line driver
  output logic             line_enable_out,       // To line driver
  output logic             power_stage_en,        // Power stage run
  output logic             clock_error,           // Clock fault level
  output logic             dc_error,              // Latched DC fault
  output logic      [23:0] audio_left,            // Left output sample
  output logic      [23:0] audio_right,           // Right output sample
  output logic             audio_valid            // New stereo pair
);
  localparam int DCW = $clog2(DC_FRAMES + 1);

  typedef struct packed {
    logic [1:0]     tg;
    logic           tg_d;
    logic [5:0]     pin_m, pin_s;
    logic [7:0]     ctrl, path, vcfg, vol, rdata, cur;
    logic [19:0]    clip;
    logic [2:0]     ramp;
    logic [11:0]    per;
    logic           clk_err, dc_err, dc_pos, valid;
    logic [DCW-1:0] dc_cnt;
    logic [23:0]    avg_l, avg_r, out_l, out_r;
  } core_st_t;
  core_st_t q, d;

  logic [23:0] rx_word;
  logic        rx_right, rx_ok, rx_tog;
  logic        sw, strb, run, bypass, fade_off, clip_en;
  logic [1:0]  fmt_eff;
  logic [7:0]  tgt;
  logic [11:0] min_per;
  logic [23:0] lim;

  // Configuration seen by the receiver and path
  // pins force I2S
  assign sw       = q.pin_s[audio_path_pkg::PIN_SW];
  assign fmt_eff  = sw ? q.path[audio_path_pkg::FMT_LSB +: 2] : audio_path_pkg::FMT_I2S;
  assign bypass   = sw & q.path[audio_path_pkg::HPF_BYP_BIT];
  assign fade_off = sw & q.vcfg[audio_path_pkg::FADE_OFF_BIT];
  assign tgt      = sw ? q.vol : audio_path_pkg::VOL_ZERO_DB;
  // soft clip pin live in both modes
  assign clip_en  = q.pin_s[audio_path_pkg::PIN_SOFT];
  assign lim      = clip_en ? {q.clip, 4'h0} : 24'h7FFFFF;
  // double speed only in register mode
  assign min_per  = (sw & q.path[audio_path_pkg::DSPEED_BIT]) ? 12'(audio_path_pkg::DS_MIN_CYC)
                                                               : 12'(audio_path_pkg::SS_MIN_CYC);
  assign run      = q.pin_s[audio_path_pkg::PIN_SD] & (!sw | q.ctrl[audio_path_pkg::SD_BIT]);
  assign strb     = q.tg[1] != q.tg_d;

  frame_rx u_rx (
    .serial_bit_clock    (serial_bit_clock),
    .resetn              (resetn),
    .channel_frame_clock (channel_frame_clock),
    .serial_data         (serial_data),
    .fmt                 (fmt_eff),
    .wl                  (sw ? audio_path_pkg::WL_BITS[q.path[audio_path_pkg::WL_LSB +: 2]] : 5'h18),
    .word                (rx_word),
    .chan_r              (rx_right),
    .ok                  (rx_ok),
    .tog                 (rx_tog)
  );

  // Saturate a wide value to plus or minus a limit
  function automatic logic [23:0] sat24(input logic signed [63:0] v, input logic [23:0] l);
    logic signed [63:0] pl;
    pl = $signed({40'h0, l});
    if (v > pl)
      return l;
    else if (v < -pl)
      return 24'(-pl);
    else
      return v[23:0];
  endfunction

  // Register port, filter, gain, clip and checks
  always_comb begin
    logic signed [23:0] avg, y;
    logic signed [24:0] e;
    logic signed [63:0] prod;
    logic [8:0]  v;
    logic [4:0]  ex;
    logic [3:0]  r;
    logic [23:0] res;
    logic [DCW-1:0] nc;
    logic        big;
    {avg, y, e, prod, v, ex, r, res, nc, big} = '0;
    d = q;
    d.valid = 1'b0;
    d.tg    = {q.tg[0], rx_tog};
    d.tg_d  = q.tg[1];
    d.pin_m = {sw_mode, line_driver_uv_enable, line_driver_mute, soft_clip_pin, speaker_fault_n_i,
               speaker_shutdown_n};
    d.pin_s = q.pin_m;
    if (reg_wr && sw) begin
      case (reg_addr)
        audio_path_pkg::CTRL_OFS:  d.ctrl = reg_wdata;
        audio_path_pkg::PATH_OFS:  d.path = reg_wdata;
        audio_path_pkg::VCFG_OFS:  d.vcfg = reg_wdata;
        audio_path_pkg::VOL_OFS:   d.vol = reg_wdata;
        audio_path_pkg::CLIP0_OFS: d.clip[7:0] = reg_wdata;
        audio_path_pkg::CLIP1_OFS: d.clip[15:8] = reg_wdata;
        audio_path_pkg::CLIP2_OFS: d.clip[19:16] = reg_wdata[3:0];
        default: ;
      endcase
    end
    case (reg_addr)
      audio_path_pkg::CTRL_OFS:  d.rdata = q.ctrl;
      audio_path_pkg::PATH_OFS:  d.rdata = q.path;
      audio_path_pkg::VCFG_OFS:  d.rdata = q.vcfg;
      audio_path_pkg::VOL_OFS:   d.rdata = q.vol;
      audio_path_pkg::STAT_OFS:  d.rdata = {4'h0, !q.pin_s[audio_path_pkg::PIN_FLT], power_stage_en,
                                            q.dc_err, q.clk_err};
      audio_path_pkg::CLIP0_OFS: d.rdata = q.clip[7:0];
      audio_path_pkg::CLIP1_OFS: d.rdata = q.clip[15:8];
      audio_path_pkg::CLIP2_OFS: d.rdata = {4'h0, q.clip[19:16]};
      default:                   d.rdata = 8'h00;
    endcase
    avg = rx_right ? q.avg_r : q.avg_l;
    e   = {rx_word[23], rx_word} - {avg[23], avg};
    y   = bypass ? rx_word : sat24(64'(e), 24'h7FFFFF);
    v    = 9'(q.cur) + audio_path_pkg::VOL_BIAS + audio_path_pkg::BOOST_STEPS;
    ex   = 5'(v / 9'h00C);
    r    = 4'(v % 9'h00C);
    prod = 64'(y * $signed({1'b0, audio_path_pkg::GAIN_MANT[r]}));
    prod = (prod <<< ex) >>> (15 + audio_path_pkg::UNITY_EXP);
    res  = (q.cur == 8'h00) ? 24'h000000 : sat24(prod, lim);
    big  = res[23] ? ($signed(res) < -$signed({1'b0, audio_path_pkg::DC_LEVEL}))
                   : (res > audio_path_pkg::DC_LEVEL);
    nc   = (big && (res[23] != q.dc_pos)) ? q.dc_cnt + DCW'(1) : DCW'(big);
    // Measure frame period
    if (q.per != 12'hFFF)
      d.per = q.per + 12'h001;
    if (!run)
      d.dc_err = 1'b0;
    if (strb) begin
      if (rx_right) begin
        d.avg_r = 24'(avg + 24'(e >>> audio_path_pkg::HPF_SHIFT));
        d.out_r = res;
        d.valid = 1'b1;
        d.per   = 12'h000;
        // error clears on a good frame
        d.clk_err = !rx_ok || (q.per < min_per);
        d.ramp = q.ramp + 3'h1;
        if (q.ramp == audio_path_pkg::RAMP_LAST && q.cur != tgt)
          d.cur = (q.cur < tgt) ? q.cur + 8'h01 : q.cur - 8'h01;
        d.dc_pos = !res[23];
        d.dc_cnt = nc;
        if (32'(nc) >= DC_FRAMES)
          d.dc_err = 1'b1;
      end else begin
        d.avg_l = 24'(avg + 24'(e >>> audio_path_pkg::HPF_SHIFT));
        d.out_l = res;
        if (!rx_ok)
          d.clk_err = 1'b1;
      end
    end
    if (q.per >= 12'(audio_path_pkg::STOP_CYC))
      d.clk_err = 1'b1;
    if (fade_off)
      d.cur = tgt;
    if (!resetn) begin
      d = '0;
      d.ctrl = audio_path_pkg::CTRL_RST;
      d.path = audio_path_pkg::PATH_RST;
      d.vcfg = audio_path_pkg::VCFG_RST;
      d.vol  = audio_path_pkg::VOL_ZERO_DB;
      d.cur  = audio_path_pkg::VOL_ZERO_DB;
      d.clip = audio_path_pkg::CLIP_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  // Outputs
  // fault stops the power stage
  assign power_stage_en     = run & !q.dc_err & !q.clk_err;
  assign speaker_fault_n_o  = 1'b0;
  assign speaker_fault_n_oe = q.dc_err | q.clk_err;
  // line driver follows its own pins
  assign line_mute_out      = q.pin_s[audio_path_pkg::PIN_MUTE];
  assign line_enable_out    = q.pin_s[audio_path_pkg::PIN_UVE];
  assign clock_error        = q.clk_err;
  assign dc_error           = q.dc_err;
  assign audio_left         = q.out_l;
  assign audio_right        = q.out_r;
  assign audio_valid        = q.valid;
  assign reg_rdata          = q.rdata;

  default clocking core_cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence right_word_s;
    strb && rx_right;
  endsequence
  sequence vol_moved_s;
    (q.cur != $past(q.cur)) && !$past(fade_off) && $past(resetn);
  endsequence

  mute_out_a: assert property (right_word_s and (q.cur == 8'h00) |=> audio_right == 24'h000000)
    else $error("muted volume gave nonzero sample");
  ramp_rate_a: assert property (vol_moved_s |-> $past(strb && rx_right && q.ramp == audio_path_pkg::RAMP_LAST))
    else $error("volume stepped outside eighth frame");
  ramp_step_a: assert property (vol_moved_s |-> (8'(q.cur - $past(q.cur)) == 8'h01)
                                              || (8'($past(q.cur) - q.cur) == 8'h01))
    else $error("volume step larger than half dB");
  fade_off_a: assert property (fade_off ##1 fade_off |-> q.cur == $past(tgt))
    else $error("volume ramped with fade disabled");
  clip_bound_a: assert property (audio_valid && $past(clip_en) |->
                                 ($signed(audio_right) <= $signed({1'b0, $past(lim)}))
                                 && ($signed(audio_right) >= -$signed({1'b0, $past(lim)})))
    else $error("sample beyond clip level");
  dc_hold_a: assert property (dc_error && run |=> dc_error)
    else $error("dc fault released without shutdown");
  dc_stage_a: assert property ($rose(dc_error) |-> !power_stage_en ##1 !power_stage_en)
    else $error("power stage on during dc fault");
  clk_stop_a: assert property (q.per >= 12'(audio_path_pkg::STOP_CYC) |=> clock_error)
    else $error("stopped clock not flagged");
  clk_resume_a: assert property (right_word_s and (rx_ok && q.per >= min_per && clock_error
                                 && q.per < 12'(audio_path_pkg::STOP_CYC)) |=> !clock_error)
    else $error("clock error did not recover");
  pin_mode_a: assert property (!sw |-> !bypass && fmt_eff == audio_path_pkg::FMT_I2S)
    else $error("pin mode allowed bypass or other format");
endmodule

// File: verilog/audio_path_pkg.sv
// Constants for the serial audio input and volume path.
// Assumes a 50 MHz core clock and an 8-bit register port.
package audio_path_pkg;
  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS  = 8'h01;
  localparam logic [7:0] PATH_OFS  = 8'h02;
  localparam logic [7:0] VCFG_OFS  = 8'h03;
  localparam logic [7:0] VOL_OFS   = 8'h04;
  localparam logic [7:0] STAT_OFS  = 8'h08;
  localparam logic [7:0] CLIP0_OFS = 8'h10;
  localparam logic [7:0] CLIP1_OFS = 8'h11;
  localparam logic [7:0] CLIP2_OFS = 8'h12;
  localparam int SD_BIT      = 0;
  localparam int FMT_LSB     = 0;
  localparam int WL_LSB      = 2;
  localparam int DSPEED_BIT  = 4;
  localparam int HPF_BYP_BIT = 7;
  localparam int FADE_OFF_BIT = 7;
  localparam logic [7:0]  CTRL_RST = 8'h01;
  localparam logic [7:0]  PATH_RST = 8'h0C;
  localparam logic [7:0]  VCFG_RST = 8'h00;
  localparam logic [19:0] CLIP_RST = 20'hFFFFF;
  // ----------------------------------------
  // Formats, word lengths, pins
  // ----------------------------------------
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ  = 2'h1;
  localparam logic [1:0] FMT_RJ  = 2'h2;
  localparam logic [4:0] WL_BITS [4] = '{5'h10, 5'h12, 5'h14, 5'h18};
  localparam int PIN_SD = 0;
  localparam int PIN_FLT = 1;
  localparam int PIN_SOFT = 2;
  localparam int PIN_MUTE = 3;
  localparam int PIN_UVE = 4;
  localparam int PIN_SW = 5;
  // ----------------------------------------
  // Gain
  // ----------------------------------------
  localparam logic [7:0] VOL_ZERO_DB = 8'hCF;
  localparam logic [8:0] VOL_BIAS    = 9'h009;
  localparam logic [8:0] BOOST_STEPS = 9'h00C;
  localparam int UNITY_EXP = 18;
  localparam int HPF_SHIFT = 10;
  localparam logic [2:0] RAMP_LAST = 3'h7;
  localparam logic [15:0] GAIN_MANT [12] = '{16'h8000, 16'h87A6, 16'h8FAD, 16'h9838, 16'hA14B, 16'hAAE8,
                                              16'hB504, 16'hBFC8, 16'hCB2F, 16'hD744, 16'hE411, 16'hF1A1};
  localparam logic [23:0] DC_LEVEL = 24'h080000;
  // ----------------------------------------
  // Clock checking
  // ----------------------------------------
  localparam int CORE_HZ      = 50000000;
  localparam int SS_MAX_FS_HZ = 48000;
  localparam int DS_MAX_FS_HZ = 96000;
  localparam int MIN_FS_HZ    = 32000;
  localparam int RATE_TOL_CYC = 16;
  localparam int SS_MIN_CYC   = CORE_HZ / SS_MAX_FS_HZ - RATE_TOL_CYC;
  localparam int DS_MIN_CYC   = CORE_HZ / DS_MAX_FS_HZ - RATE_TOL_CYC;
  localparam int STOP_CYC     = 2 * CORE_HZ / MIN_FS_HZ;
endpackage

// File: tb/audio_source.sv
// Audio source model: bit clock, frame clock and serial data.
// Assumes the bench calls send_frame; the bit clock stands still between calls.
`timescale 1ns/100ps
module audio_source (
  output logic serial_bit_clock,    // Bit clock, 30 ns
  output logic channel_frame_clock, // Frame clock
  output logic serial_data          // Serial data
);
  initial begin
    serial_bit_clock = 1'b0;
    channel_frame_clock = 1'b1;
    serial_data = 1'b0;
  end

  // ----
  // One frame of 64 bit clocks, then a pause
  // ----
  // 64 clocks per frame
  task automatic send_frame(input logic [1:0] fmt, input int nb, input logic [23:0] lw, input logic [23:0] rw,
                            input int gap);
    int          pos;
    logic [23:0] w;
    for (int b = 0; b < 64; b++) begin
      w = (b < 32) ? lw : rw;
      channel_frame_clock = (fmt == audio_path_pkg::FMT_I2S) ? (b >= 32) : (b < 32);
      pos = b % 32 - ((fmt == audio_path_pkg::FMT_I2S) ? 1 : (fmt == audio_path_pkg::FMT_RJ) ? 32 - nb : 0);
      serial_data = (pos >= 0 && pos < nb) ? w[23 - pos] : ~serial_data; // Unused slots toggle
      #15 serial_bit_clock = 1'b1;
      #15 serial_bit_clock = 1'b0;
    end
    #(gap);
  endtask
endmodule

// File: tb/serial_audio_input_volume_path_tb.sv
// Testbench of the serial audio input and volume path.
// Assumes the package and the audio source model are compiled first.
`timescale 1ns/100ps
module serial_audio_input_volume_path_tb;
  typedef struct {logic [1:0] fmt; logic [1:0] wl; logic [7:0] code; logic clp;
                  logic [23:0] l; logic [23:0] r; logic [23:0] el; logic [23:0] er;} row_t;
  localparam int NB [4] = '{16, 18, 20, 24};
  row_t rows [7] = '{
    '{2'h0, 2'h3, 8'hC3, 1'b0, 24'h123456, 24'hFEDCBA, 24'h123456, 24'hFEDCBA},
    '{2'h1, 2'h0, 8'hC3, 1'b0, 24'h1234AB, 24'hFF8077, 24'h123400, 24'hFF8000},
    '{2'h2, 2'h2, 8'hC3, 1'b0, 24'hABCDEF, 24'hF0001F, 24'hABCDE0, 24'hF00010},
    '{2'h0, 2'h3, 8'hCF, 1'b0, 24'h500000, 24'h030000, 24'h7FFFFF, 24'h060000},
    '{2'h1, 2'h1, 8'hDB, 1'b0, 24'hA00000, 24'h00FFFF, 24'h800001, 24'h03FF00},
    '{2'h2, 2'h3, 8'h00, 1'b0, 24'h123456, 24'h654321, 24'h000000, 24'h000000},
    '{2'h0, 2'h3, 8'hC3, 1'b1, 24'h300000, 24'h010000, 24'h100000, 24'h010000}};
  localparam logic [7:0] RA [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h20};
  localparam logic [7:0] RV [5] = '{8'h01, 8'h0C, 8'h00, 8'hCF, 8'h00};

  logic        core_clk = 1'b0;
  logic        resetn, sw_mode, reg_wr, speaker_shutdown_n, soft_clip_pin, line_driver_mute, line_driver_uv_enable;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic        serial_bit_clock, channel_frame_clock, serial_data, fault_oe, fault_o, line_mute_out, line_enable_out;
  logic        power_stage_en, clock_error, dc_error, audio_valid;
  logic [23:0] audio_left, audio_right, lw, rw;
  logic [1:0]  fmt;
  int          nb, failures, cmp_count, cycles, vcount, nv;

  always #10 core_clk = ~core_clk;

  audio_source i_src (.serial_bit_clock(serial_bit_clock), .channel_frame_clock(channel_frame_clock),
                      .serial_data(serial_data));

  serial_audio_input_volume_path #(.DC_FRAMES(4)) i_dut (.core_clk(core_clk), .resetn(resetn),
    .serial_bit_clock(serial_bit_clock), .channel_frame_clock(channel_frame_clock), .serial_data(serial_data),
    .sw_mode(sw_mode), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .speaker_shutdown_n(speaker_shutdown_n), .speaker_fault_n_i(fault_oe ? fault_o : 1'b1),
    .speaker_fault_n_o(fault_o),
    .speaker_fault_n_oe(fault_oe), .soft_clip_pin(soft_clip_pin), .line_driver_mute(line_driver_mute),
    .line_driver_uv_enable(line_driver_uv_enable), .line_mute_out(line_mute_out),
    .line_enable_out(line_enable_out), .power_stage_en(power_stage_en), .clock_error(clock_error),
    .dc_error(dc_error), .audio_left(audio_left), .audio_right(audio_right), .audio_valid(audio_valid));

  // ----
  // Shared tasks
  // ----
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
    d = reg_rdata;
  endtask
  task automatic play(input int n, input int gap);
    repeat (n) i_src.send_frame(fmt, nb, lw, rw, gap);
    repeat (20) @(posedge core_clk);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Count stereo pairs handed out
  always @(posedge core_clk) begin
    if (audio_valid === 1'b1)
      vcount++;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      complete_run();
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    {resetn, sw_mode, reg_wr, reg_addr, reg_wdata, soft_clip_pin, line_driver_mute, line_driver_uv_enable} = '0;
    speaker_shutdown_n = 1'b1;
    {fmt, nb, lw, rw} = '0;
    // Link side needs bit clock edges during reset
    fork
      i_src.send_frame(2'h0, 24, 24'h0, 24'h0, 0);
      begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
      end
    join
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      rd(RA[i]);
      check("reset value", {16'h0, d}, {16'h0, RV[i]});
    end
    wr(audio_path_pkg::PATH_OFS, 8'h8D);
    rd(audio_path_pkg::PATH_OFS);
    check("pin mode path", {16'h0, d}, 24'h00000C);
    line_driver_mute <= 1'b1;
    line_driver_uv_enable <= 1'b1;
    speaker_shutdown_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    check("line pins", {21'h0, line_mute_out, line_enable_out, power_stage_en}, 24'h000006);
    speaker_shutdown_n <= 1'b1;
    sw_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    wr(audio_path_pkg::VCFG_OFS, 8'h80);
    wr(audio_path_pkg::CLIP0_OFS, 8'h00);
    wr(audio_path_pkg::CLIP1_OFS, 8'h00);
    wr(audio_path_pkg::CLIP2_OFS, 8'h01);
    // Table of formats, word lengths, gains and clipping
    foreach (rows[i]) begin
      soft_clip_pin <= rows[i].clp;
      wr(audio_path_pkg::PATH_OFS, {1'b1, 3'h0, rows[i].wl, rows[i].fmt});
      wr(audio_path_pkg::VOL_OFS, rows[i].code);
      fmt = rows[i].fmt;
      nb = NB[rows[i].wl];
      lw = rows[i].l;
      rw = rows[i].r;
      play(3, 0);
      check("left", audio_left, rows[i].el);
      check("right", audio_right, rows[i].er);
    end
    // Ramp from minus 6 dB to 0 dB with fade on
    soft_clip_pin <= 1'b0;
    wr(audio_path_pkg::VOL_OFS, 8'hC3);
    lw = 24'h200000;
    rw = 24'h0;
    play(3, 0);
    wr(audio_path_pkg::VCFG_OFS, 8'h00);
    wr(audio_path_pkg::VOL_OFS, 8'hCF);
    play(16, 0);
    check("ramp midway", {23'h0, (audio_left > 24'h200000 && audio_left < 24'h400000)}, 24'h1);
    play(95, 0);
    check("ramp end", audio_left, 24'h400000);
    // DC fault latches until shutdown is toggled
    rw = 24'h400000;
    play(8, 0);
    check("dc fault", {21'h0, dc_error, power_stage_en, fault_oe}, 24'h000005);
    rd(audio_path_pkg::STAT_OFS);
    check("status", {16'h0, d}, 24'h00000B);
    rw = 24'h0;
    play(3, 0);
    check("dc latched", {23'h0, dc_error}, 24'h1);
    speaker_shutdown_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    speaker_shutdown_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    check("dc cleared", {23'h0, dc_error}, 24'h0);
    // Slow frames clear the clock fault, a stop raises it
    nv = vcount;
    play(3, 22000);
    check("clock ok", {23'h0, clock_error}, 24'h0);
    check("valid pulses", 24'(vcount - nv), 24'h000003);
    repeat (3300) @(posedge core_clk);
    check("clock stop", {22'h0, clock_error, fault_oe}, 24'h000003);
    // Faster frames pass only in double speed
    wr(audio_path_pkg::PATH_OFS, 8'h9C);
    play(3, 12000);
    check("double speed", {23'h0, clock_error}, 24'h0);
    sw_mode <= 1'b0;
    play(3, 12000);
    check("pin single speed", {23'h0, clock_error}, 24'h1);
    complete_run();
  end
endmodule
